// ### dv/pfx_checker_assertions.sv
// Checker for the equalizer filter top ports.
// Assumes it is bound to pfx_filter_top and sees its ports only.
`timescale 1ns/1ps
module pfx_checker (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [11:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   // Sample path
   input wire pfx_pkg::pfx_sample_type sample_a_in,
   input wire pfx_pkg::pfx_sample_type sample_b_in,
   input wire logic sample_valid_in,
   input wire pfx_pkg::pfx_sample_type link_a_out,
   input wire pfx_pkg::pfx_sample_type link_b_out,
   input wire logic link_a_valid_out,
   input wire logic link_b_valid_out,
   // Status
   input wire logic filter_active_out,
   input wire logic merge_active_out
);
   import pfx_pkg::*;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   logic cfg_wr;
   logic quiet;
   assign cfg_wr = reg_wr_in && reg_addr_in == FIR_CONFIG_OFFSET;
   assign quiet = sample_valid_in && !filter_active_out;
   a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
      else $error("read data not zero");
   a_read_msb: assert property (reg_rd_in && reg_addr_in == FIR_TAP0_OFFSET |=> !reg_rdata_out[TAP0_MSB])
      else $error("tap0 sign bit read back");
   a_unmapped_read: assert property (reg_rd_in && reg_addr_in != FIR_CONFIG_OFFSET &&
      reg_addr_in != FIR_TAP0_OFFSET |=> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   a_valid_follow: assert property (sample_valid_in |=> link_a_valid_out && link_b_valid_out)
      else $error("link valid missing");
   a_valid_drop: assert property (!sample_valid_in |=> !link_a_valid_out && !link_b_valid_out)
      else $error("link valid without sample");
   a_bypass_a: assert property (quiet && !$past(reg_wr_in) |=> link_a_out == $past(sample_a_in))
      else $error("channel a not bypassed");
   a_bypass_b: assert property (quiet && !$past(reg_wr_in) |=> link_b_out == $past(sample_b_in))
      else $error("channel b not bypassed");
   a_merge_flag: assert property (cfg_wr |=> ##1 merge_active_out == $past(reg_wdata_in[MERGE_BIT], 2))
      else $error("merge status wrong");
   a_mode_flag: assert property (cfg_wr |=> ##1 filter_active_out == ($past(reg_wdata_in[1:0], 2) == 2'h2))
      else $error("filter status wrong");
endmodule
bind pfx_filter_top pfx_checker u_chk (.mclk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
   .reg_rdata_out, .sample_a_in, .sample_b_in, .sample_valid_in, .link_a_out, .link_b_out, .link_a_valid_out,
   .link_b_valid_out, .filter_active_out, .merge_active_out);

// ### dv/pfx_conv_model.sv
// Converter core model: steady per-channel levels as samples.
// Assumes the bench sets levels and pacing after clock edges.
`timescale 1ns/1ps
module pfx_conv_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Control
   input wire logic run_in,
   input wire logic slow_in,
   input wire pfx_pkg::pfx_sample_type level_a_in,
   input wire pfx_pkg::pfx_sample_type level_b_in,
   // Samples
   output pfx_pkg::pfx_sample_type sample_a_out,
   output pfx_pkg::pfx_sample_type sample_b_out,
   output logic valid_out
);
   import pfx_pkg::*;
   logic tick;
   logic next_tick;
   logic next_valid;
   always_comb begin
      next_tick = ~tick;
      next_valid = run_in && (!slow_in || tick);
   end
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         tick <= 1'b0;
         valid_out <= 1'b0;
      end else begin
         tick <= next_tick;
         valid_out <= next_valid;
      end
   end
   // Invalid cycles show the inverse, never a held value
   assign sample_a_out = valid_out ? level_a_in : ~level_a_in;
   assign sample_b_out = valid_out ? level_b_in : ~level_b_in;
endmodule

// ### dv/pfx_filter_top_test.sv
// Bench for the equalizer filter block.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module pfx_filter_top_test;
   import pfx_pkg::*;
   localparam int LA = 12'h3E8;
   localparam int LB = 12'h1F4;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic run = 1'b0;
   logic slow = 1'b0;
   logic [15:0] rdata;
   pfx_sample_type sa, sb, lao, lbo;
   logic sv, lav, lbv, fa, ma;
   pfx_side_type ca_side [SIDE_TAPS-1];
   pfx_side_type cb_side [SIDE_TAPS];
   pfx_center_type ca_ctr = 18'h00000;
   int failures = 0;
   int n_tests = 0;
   // ****
   // Rows: config, tap0, tap1, center
   // ****
   int tbl [10][4] = '{'{8'h00, 12'h400, 12'h000, 18'h00000}, '{8'h20, 12'h400, 12'h000, 18'h00000},
      '{8'h40, 12'h400, 12'h000, 18'h00000}, '{8'h02, 12'h400, 12'h000, 18'h00000},
      '{8'h1A, 12'h400, 12'h000, 18'h00000}, '{8'h5A, 12'h400, 12'h000, 18'h00000},
      '{8'h02, 12'h400, 12'h000, 18'h10000}, '{8'h1A, 12'h400, 12'h000, 18'h10000},
      '{8'h1A, 12'h000, 12'h400, 18'h00000}, '{8'h3A, 12'h200, 12'h400, 18'h00000}};
   initial begin
      forever #25 mclk_in = ~mclk_in;
   end
   pfx_conv_model u_conv (.mclk_in(mclk_in), .rst_in(rst_in), .run_in(run), .slow_in(slow),
      .level_a_in(12'h3E8), .level_b_in(12'h1F4), .sample_a_out(sa), .sample_b_out(sb), .valid_out(sv));
   pfx_filter_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sample_a_in(sa), .sample_b_in(sb),
      .sample_valid_in(sv), .coeff_a_side_in(ca_side), .coeff_a_center_in(ca_ctr), .coeff_b_side_in(cb_side),
      .coeff_b_center_in(18'h00000), .link_a_out(lao), .link_b_out(lbo), .link_a_valid_out(lav),
      .link_b_valid_out(lbv), .filter_active_out(fa), .merge_active_out(ma));
   // Expected lane output: x own newest sample, y the other channel
   function automatic int calc(int cf, int t0, int t1, int c, int x, int y, bit lane_b);
      int w;
      if (cf[1:0] != 2) return x;
      if (lane_b && !cf[6] && !cf[5]) return 0;
      w = cf[5] ? y : x;
      return (((t0 * x + t1 * w) <<< cf[4:2]) + c * x) >>> 16;
   endfunction
   task automatic test_done;
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] got);
      n_tests++;
      if (got !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic wr_reg(logic [11:0] a, logic [15:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(logic [11:0] a, logic [15:0] e);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask
   task automatic run_row(int r);
      int i;
      int cf;
      cf = tbl[r][0];
      wr_reg(FIR_TAP0_OFFSET, 16'(tbl[r][1]));
      ca_side[0] <= 12'(tbl[r][2]);
      ca_ctr <= 18'(tbl[r][3]);
      wr_reg(FIR_CONFIG_OFFSET, 16'(cf));
      run <= 1'b1;
      slow <= r[0];
      repeat (30) @(posedge mclk_in);
      #1;
      i = 0;
      while (lav !== 1'b1 && i < 4) begin
         @(posedge mclk_in);
         #1;
         i++;
      end
      if (i == 4) begin
         failures++;
         test_done;
      end
      chk("link_a", 16'(calc(cf, tbl[r][1], tbl[r][2], tbl[r][3], LA, LB, 1'b0)), 16'(lao));
      chk("link_b", 16'(calc(cf, tbl[r][1], tbl[r][2], tbl[r][3], LB, LA, 1'b1)), 16'(lbo));
      chk("status", {14'h0000, cf[1:0] == 2'h2, cf[5]}, {14'h0000, fa, ma});
      @(posedge mclk_in);
      run <= 1'b0;
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      foreach (ca_side[k]) ca_side[k] = 12'h000;
      foreach (cb_side[k]) cb_side[k] = 12'h000;
      repeat (20) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd_reg(FIR_CONFIG_OFFSET, 16'h0000);
      rd_reg(FIR_TAP0_OFFSET, 16'h0000);
      wr_reg(FIR_TAP0_OFFSET, 16'hFFFF);
      rd_reg(FIR_TAP0_OFFSET, 16'hF7FF);
      wr_reg(FIR_CONFIG_OFFSET, 16'h00DA);
      rd_reg(FIR_CONFIG_OFFSET, 16'h00DA);
      wr_reg(12'h404, 16'h1234);
      rd_reg(12'h404, 16'h0000);
      rd_reg(FIR_CONFIG_OFFSET, 16'h00DA);
      for (int r = 0; r < 10; r++) run_row(r);
      test_done;
   end
endmodule

// ### logic/pfx_filter_top.sv
// Equalizer filter configuration, first coefficient and sample path.
// Assumes samples and remaining coefficients come from logic on mclk_in.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// - Share flag gives channel B channel A coefficients
// - Merge flag combines both filters into one
// - Merged filter sees one interleaved sample stream
// - Side weight scales all but center coefficient
// - Larger weight: wider range, coarser steps
// - Side LSB is two to min(selector, 6) minus sixteen
// - Side weight resets to zero
// - Mode zero disables, two enables filter
// - First tap is 12-bit signed value
// - First tap is tap one of A or merged
// - First tap readback returns zero sign bit
// - Nine taps, center coefficient 18 bits wide
module pfx_filter_top (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [pfx_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [pfx_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [pfx_pkg::DATA_W-1:0] reg_rdata_out,
   // Converter samples
   input wire pfx_pkg::pfx_sample_type sample_a_in,
   input wire pfx_pkg::pfx_sample_type sample_b_in,
   input wire logic sample_valid_in,
   // Remaining coefficients
   input wire pfx_pkg::pfx_side_type coeff_a_side_in [pfx_pkg::SIDE_TAPS-1],
   input wire pfx_pkg::pfx_center_type coeff_a_center_in,
   input wire pfx_pkg::pfx_side_type coeff_b_side_in [pfx_pkg::SIDE_TAPS],
   input wire pfx_pkg::pfx_center_type coeff_b_center_in,
   // Link transmitter samples
   output pfx_pkg::pfx_sample_type link_a_out,
   output pfx_pkg::pfx_sample_type link_b_out,
   output logic link_a_valid_out,
   output logic link_b_valid_out,
   // Status
   output logic filter_active_out,
   output logic merge_active_out
);
   import pfx_pkg::*;

   // ****************************************
   // Register state
   // ****************************************
   logic [7:0] fir_config;
   logic [15:0] fir_tap0_coefficient;
   logic [15:0] rd_data;
   logic [7:0] next_config;
   logic [15:0] next_tap0;
   logic [15:0] next_rd_data;
   logic filter_active;
   logic merge_active;
   logic next_filter_active;
   logic next_merge_active;

   // ****************************************
   // Configuration fields
   // ****************************************
   logic [1:0] filter_mode_sel;
   logic [2:0] side_weight_sel;
   logic filter_merge_flag;
   logic coeff_share_flag;
   pfx_side_type tap0_coeff;

   assign filter_mode_sel = fir_config[MODE_LSB +: MODE_W];
   assign side_weight_sel = fir_config[SCW_LSB +: SCW_W];
   assign filter_merge_flag = fir_config[MERGE_BIT];
   assign coeff_share_flag = fir_config[SHARE_BIT];
   assign tap0_coeff = fir_tap0_coefficient[TAP0_MSB:0];

   // ****************************************
   // Address decode
   // ****************************************
   logic sel_config;
   logic sel_tap0;
   logic lane_enable;

   assign sel_config = (reg_addr_in == FIR_CONFIG_OFFSET);
   assign sel_tap0 = (reg_addr_in == FIR_TAP0_OFFSET);
   assign lane_enable = (filter_mode_sel == MODE_ENABLED);

   // ****************************************
   // Register writes and reads
   // ****************************************
   always_comb begin
      next_config = fir_config;
      next_tap0 = fir_tap0_coefficient;
      next_rd_data = '0;
      if (reg_wr_in) begin
         if (sel_config) begin
            next_config = reg_wdata_in[7:0];
         end
         if (sel_tap0) begin
            next_tap0 = reg_wdata_in;
         end
      end
      if (reg_rd_in) begin
         if (sel_config) begin
            next_rd_data = {8'h00, fir_config};
         end
         if (sel_tap0) begin
            next_rd_data = fir_tap0_coefficient;
            next_rd_data[TAP0_MSB] = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         fir_config <= FIR_CONFIG_RESET;
         fir_tap0_coefficient <= FIR_TAP0_RESET;
         rd_data <= '0;
      end else begin
         fir_config <= next_config;
         fir_tap0_coefficient <= next_tap0;
         rd_data <= next_rd_data;
      end
   end

   assign reg_rdata_out = rd_data;

   // ****************************************
   // Mode decode
   // ****************************************
   always_comb begin
      next_filter_active = (filter_mode_sel == MODE_ENABLED);
      next_merge_active = filter_merge_flag;
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         filter_active <= 1'b0;
         merge_active <= 1'b0;
      end else begin
         filter_active <= next_filter_active;
         merge_active <= next_merge_active;
      end
   end

   assign filter_active_out = filter_active;
   assign merge_active_out = merge_active;

   // ****************************************
   // Sample history
   // ****************************************
   pfx_sample_type hist_a [SIDE_TAPS];
   pfx_sample_type hist_b [SIDE_TAPS];
   pfx_sample_type next_hist_a [SIDE_TAPS];
   pfx_sample_type next_hist_b [SIDE_TAPS];

   always_comb begin
      next_hist_a = hist_a;
      next_hist_b = hist_b;
      if (sample_valid_in) begin
         next_hist_a[0] = sample_a_in;
         next_hist_b[0] = sample_b_in;
         for (int i = 1; i < SIDE_TAPS; i++) begin
            next_hist_a[i] = hist_a[i-1];
            next_hist_b[i] = hist_b[i-1];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         for (int i = 0; i < SIDE_TAPS; i++) begin
            hist_a[i] <= '0;
            hist_b[i] <= '0;
         end
      end else begin
         hist_a <= next_hist_a;
         hist_b <= next_hist_b;
      end
   end

   // ****************************************
   // Tap windows
   // ****************************************
   pfx_sample_type win_a [TAPS];
   pfx_sample_type win_b [TAPS];
   pfx_sample_type dual_a [TAPS];
   pfx_sample_type dual_b [TAPS];
   pfx_sample_type mrg_a [TAPS];
   pfx_sample_type mrg_b [TAPS];

   genvar k;
   generate
      for (k = 0; k < TAPS; k++) begin : g_win
         localparam int J = k / 2;
         localparam int JO = (k + 1) / 2;
         if (k == 0) begin : g_first
            assign dual_a[k] = sample_a_in;
            assign dual_b[k] = sample_b_in;
            assign mrg_a[k] = sample_a_in;
            assign mrg_b[k] = sample_b_in;
         end else begin : g_rest
            assign dual_a[k] = hist_a[k-1];
            assign dual_b[k] = hist_b[k-1];
            if (k % 2 == 0) begin : g_even
               assign mrg_a[k] = hist_a[J-1];
               assign mrg_b[k] = hist_b[J-1];
            end else begin : g_odd
               assign mrg_a[k] = hist_b[JO-1];
               if (J == 0) begin : g_cur
                  assign mrg_b[k] = sample_a_in;
               end else begin : g_old
                  assign mrg_b[k] = hist_a[J-1];
               end
            end
         end
         assign win_a[k] = filter_merge_flag ? mrg_a[k] : dual_a[k];
         assign win_b[k] = filter_merge_flag ? mrg_b[k] : dual_b[k];
      end
   endgenerate

   // ****************************************
   // Coefficient sets
   // ****************************************
   pfx_side_type side_a [SIDE_TAPS];
   pfx_side_type side_b [SIDE_TAPS];
   pfx_center_type center_b;
   logic use_a_for_b;

   assign use_a_for_b = coeff_share_flag | filter_merge_flag;
   assign center_b = use_a_for_b ? coeff_a_center_in : coeff_b_center_in;

   generate
      for (k = 0; k < SIDE_TAPS; k++) begin : g_coeff
         if (k == 0) begin : g_tap0
            assign side_a[k] = tap0_coeff;
         end else begin : g_tapn
            assign side_a[k] = coeff_a_side_in[k-1];
         end
         assign side_b[k] = use_a_for_b ? side_a[k] : coeff_b_side_in[k];
      end
   endgenerate

   // ****************************************
   // Filter lanes
   // ****************************************
   pfx_lane u_lane_a (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .win_in(win_a),
      .side_in(side_a),
      .center_in(coeff_a_center_in),
      .scw_in(side_weight_sel),
      .enable_in(lane_enable),
      .valid_in(sample_valid_in),
      .y_out(link_a_out),
      .valid_out(link_a_valid_out)
   );

   pfx_lane u_lane_b (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .win_in(win_b),
      .side_in(side_b),
      .center_in(center_b),
      .scw_in(side_weight_sel),
      .enable_in(lane_enable),
      .valid_in(sample_valid_in),
      .y_out(link_b_out),
      .valid_out(link_b_valid_out)
   );

   // ****************************************
   // Elaboration checks
   // ****************************************
   generate
      if (TAPS != 2 * CENTER_TAP + 1 || SIDE_TAPS != TAPS - 1) begin : g_bad_taps
         $error("tap count must be odd with the center tap in the middle");
      end
      if (TAP0_MSB != SIDE_W - 1) begin : g_bad_tap0
         $error("first tap field must match the side coefficient width");
      end
      if (CENTER_W <= SIDE_W) begin : g_bad_center
         $error("center coefficient must be wider than side ones");
      end
      if (SIDE_W + SAMPLE_W != 24 || CENTER_W + SAMPLE_W != 30) begin : g_bad_prod
         $error("lane product widths do not match the coefficient widths");
      end
      if (DATA_W != 16 || ADDR_W != 12) begin : g_bad_bus
         $error("register port must be 16 data and 12 address bits");
      end
      if (SHARE_BIT > 7 || MODE_W + SCW_W > MERGE_BIT) begin : g_bad_fields
         $error("configuration fields do not fit the configuration byte");
      end
      if (ACC_W < SIDE_W + SAMPLE_W + 4 + SCW_MAX) begin : g_bad_acc
         $error("accumulator too narrow for the largest side weight");
      end
   endgenerate

endmodule

// ### logic/pfx_lane.sv
// One filter lane: nine-tap multiply-accumulate with a registered result.
// Assumes the window and coefficients are stable in the cycle valid_in is high.
`timescale 1ns/1ps
module pfx_lane (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Window and coefficients
   input wire pfx_pkg::pfx_sample_type win_in [pfx_pkg::TAPS],
   input wire pfx_pkg::pfx_side_type side_in [pfx_pkg::SIDE_TAPS],
   input wire pfx_pkg::pfx_center_type center_in,
   input wire logic [2:0] scw_in,
   input wire logic enable_in,
   input wire logic valid_in,
   // Result
   output pfx_pkg::pfx_sample_type y_out,
   output logic valid_out
);
   import pfx_pkg::*;

   // ****************************************
   // Products
   // ****************************************
   logic signed [23:0] prod [SIDE_TAPS];
   logic signed [29:0] cprod;
   logic [2:0] scw_eff;
   logic signed [ACC_W-1:0] acc_side;
   logic signed [ACC_W-1:0] acc;
   logic signed [ACC_W-1:0] shr;
   pfx_sample_type filt;
   pfx_sample_type next_y;
   logic next_valid;

   genvar k;
   generate
      for (k = 0; k < SIDE_TAPS; k++) begin : g_prod
         localparam int W = (k < CENTER_TAP) ? k : k + 1;
         assign prod[k] = side_in[k] * win_in[W];
      end
   endgenerate

   assign cprod = center_in * win_in[CENTER_TAP];
   assign scw_eff = (scw_in > SCW_MAX) ? SCW_MAX : scw_in;

   // ****************************************
   // Accumulate, scale, saturate
   // ****************************************
   always_comb begin
      acc_side = '0;
      for (int i = 0; i < SIDE_TAPS; i++) begin
         acc_side = acc_side + ACC_W'(prod[i]);
      end
      acc = (acc_side <<< scw_eff) + ACC_W'(cprod);
      shr = acc >>> FRAC_BITS;
      if (shr > 36'sh0000007FF) begin
         filt = 12'sh7FF;
      end else if (shr < -36'sh000000800) begin
         filt = -12'sh800;
      end else begin
         filt = shr[SAMPLE_W-1:0];
      end
      next_y = enable_in ? filt : win_in[0];
      next_valid = valid_in;
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         y_out <= '0;
         valid_out <= 1'b0;
      end else begin
         y_out <= next_y;
         valid_out <= next_valid;
      end
   end

endmodule

// ### logic/pfx_pkg.sv
// Constants for the equalizer filter configuration block.
// Assumes a 12-bit register address and a 16-bit register data path.
package pfx_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam logic [11:0] FIR_CONFIG_OFFSET = 12'h400;
   localparam logic [11:0] FIR_TAP0_OFFSET = 12'h418;
   localparam logic [7:0] FIR_CONFIG_RESET = 8'h00;
   localparam logic [15:0] FIR_TAP0_RESET = 16'h0000;

   // ****************************************
   // Configuration fields
   // ****************************************
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 2;
   localparam int SCW_LSB = 2;
   localparam int SCW_W = 3;
   localparam int MERGE_BIT = 5;
   localparam int SHARE_BIT = 6;
   localparam logic [1:0] MODE_DISABLED = 2'h0;
   localparam logic [1:0] MODE_ENABLED = 2'h2;
   localparam logic [2:0] SCW_MAX = 3'h6;

   // ****************************************
   // Coefficient and sample layout
   // ****************************************
   localparam int TAP0_MSB = 11;
   localparam int TAPS = 9;
   localparam int CENTER_TAP = 4;
   localparam int SIDE_TAPS = 8;
   localparam int SIDE_W = 12;
   localparam int CENTER_W = 18;
   localparam int SAMPLE_W = 12;
   localparam int FRAC_BITS = 16;
   localparam int ACC_W = 36;

   typedef logic signed [SAMPLE_W-1:0] pfx_sample_type;
   typedef logic signed [SIDE_W-1:0] pfx_side_type;
   typedef logic signed [CENTER_W-1:0] pfx_center_type;

endpackage
